// [common/pci_cfg_pkg.sv]
package pci_cfg_pkg;
    // register byte addresses
    localparam logic [15:0] OFF_MISC  = 16'hD00C;
    localparam logic [15:0] OFF_W0_LO = 16'hD010;
    localparam logic [15:0] OFF_W0_HI = 16'hD014;
    localparam logic [15:0] OFF_W1_LO = 16'hD018;
    localparam logic [15:0] OFF_W1_HI = 16'hD01C;
    localparam logic [15:0] OFF_W2    = 16'hD020;

    // header register fields
    localparam int SELF_TEST_BIT = 31;
    localparam int MULTI_FN_BIT  = 23;
    localparam int HDR_LSB       = 16;
    localparam int HDR_W         = 7;
    localparam int TIMER_LSB     = 8;
    localparam int TIMER_FIXED   = 2;
    localparam int LINE_LSB      = 0;

    // lowest writable base bit of each window
    localparam int W0_LSB = 29;
    localparam int W1_LSB = 24;
    localparam int W2_LSB = 20;

    // low nibble: prefetch, type 00, memory space
    localparam logic [3:0] BAR_LOW_PREF = 4'h8;
    localparam logic [3:0] BAR_LOW_NP   = 4'h0;

    // reset values
    localparam logic [6:0]  HDR_RST  = 7'h00;
    localparam logic [7:0]  TIMER_RST = 8'h00;
    localparam logic [7:0]  LINE_RST  = 8'h00;
    localparam logic [2:0]  W0_RST   = 3'h0;
    localparam logic [7:0]  W1_RST   = 8'h00;
    localparam logic [11:0] W2_RST   = 12'h000;

    // burst read commands
    localparam logic [3:0] CMD_MEM_READ  = 4'h6;
    localparam logic [3:0] CMD_READ_LINE = 4'hE;
    localparam logic [3:0] CMD_READ_MULT = 4'hC;

    typedef enum logic [1:0] {
        TEN_IDLE    = 2'b00,
        TEN_COUNT   = 2'b01,
        TEN_EXPIRED = 2'b11
    } tenure_state_type;
endpackage : pci_cfg_pkg

// [dv/pci_initiator_model.sv]
`timescale 1ns/10ps
module pci_initiator_model (
    input  wire logic        mclk,       // clock
    input  wire logic        srst,       // sync reset
    input  wire logic        go,         // start an address phase
    input  wire logic [31:0] addr,       // address to present
    output logic             addr_valid, // address phase
    output logic      [31:0] pci_addr    // address lines
);
    // one-cycle address phase; lines scramble once released
    always_ff @(posedge mclk) begin
        if (srst) begin
            addr_valid <= 1'b0;
            pci_addr   <= 32'h0;
        end else if (go) begin
            addr_valid <= 1'b1;
            pci_addr   <= addr;
        end else begin
            addr_valid <= 1'b0;
            pci_addr   <= ~pci_addr;
        end
    end
endmodule : pci_initiator_model

// [dv/pci_target_config_header_bars_test.sv]
`timescale 1ns/10ps
module pci_target_config_header_bars_test;
    import pci_cfg_pkg::*;
    typedef struct {logic w; logic [15:0] a; logic [31:0] d; logic [31:0] e;} row_type;
    logic        mclk, srst, cyc_i, stb_i, we_i, ack_o, satellite_pin, eeprom_load, tenure_active, grant;
    logic        tenure_give_up, cmd_req, addr_valid, satellite_mode, go;
    logic [15:0] adr_i;
    logic [31:0] dat_i, dat_o, pci_addr, go_addr, rd;
    logic [3:0]  sel_i, read_cmd;
    logic [6:0]  eeprom_hdr;
    logic [7:0]  burst_words;
    logic [2:0]  window_hit;
    int          err_count, num_checks;
    row_type     rows[7];
    pci_target_config_header_bars u_pci_target_config_header_bars (.mclk(mclk), .srst(srst), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
        .satellite_pin(satellite_pin), .eeprom_load(eeprom_load), .eeprom_hdr(eeprom_hdr),
        .tenure_active(tenure_active), .grant(grant), .tenure_give_up(tenure_give_up), .cmd_req(cmd_req),
        .burst_words(burst_words), .read_cmd(read_cmd), .addr_valid(addr_valid), .pci_addr(pci_addr),
        .window_hit(window_hit), .satellite_mode(satellite_mode));
    pci_initiator_model u_pci_initiator_model (.mclk(mclk), .srst(srst), .go(go), .addr(go_addr),
        .addr_valid(addr_valid), .pci_addr(pci_addr));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do begin
            @(posedge mclk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (n >= 50) begin
            err_count++;
            finish_test();
        end
    endtask : wb
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, 4'hF, r);
        chk(r, e);
    endtask : rdchk
    task automatic do_reset;
        @(posedge mclk);
        srst <= 1'b1;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
    endtask : do_reset
    task automatic hit(input logic [31:0] a, input logic [2:0] e);
        @(posedge mclk);
        go      <= 1'b1;
        go_addr <= a;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk({29'h0, window_hit}, {29'h0, e});
    endtask : hit
    task automatic cmd(input logic [7:0] w, input logic [3:0] e);
        @(posedge mclk);
        cmd_req     <= 1'b1;
        burst_words <= w;
        @(posedge mclk);
        cmd_req <= 1'b0;
        @(negedge mclk);
        chk({28'h0, read_cmd}, {28'h0, e});
    endtask : cmd
    initial begin
        {cyc_i, stb_i, we_i, satellite_pin, eeprom_load, tenure_active, cmd_req, go} = '0;
        srst = 1'b1;
        grant = 1'b1;
        adr_i = 16'h0000;
        dat_i = 32'h0;
        sel_i = 4'h0;
        eeprom_hdr = 7'h00;
        burst_words = 8'h00;
        go_addr = 32'h0;
        err_count = 0;
        num_checks = 0;
        // upper bases are only read, never written
        rows = '{'{1'b1, OFF_MISC, 32'hFFFFFFFF, 32'h0000FCFF}, '{1'b1, OFF_W0_LO, 32'hFFFFFFFF, 32'hE0000008},
                 '{1'b1, OFF_W1_LO, 32'hFFFFFFFF, 32'hFF000008}, '{1'b1, OFF_W2, 32'hFFFFFFFF, 32'hFFF00000},
                 '{1'b1, 16'hD030, 32'hFFFFFFFF, 32'h00000000}, '{1'b0, OFF_W0_HI, 32'h0, 32'h00000000},
                 '{1'b0, OFF_W1_HI, 32'h0, 32'h00000000}};
        do_reset();
        rdchk(OFF_MISC, 32'h00000000);
        rdchk(OFF_W0_LO, 32'h00000008);
        rdchk(OFF_W1_LO, 32'h00000008);
        rdchk(OFF_W2, 32'h00000000);
        $display("test reset values done");
        foreach (rows[i]) begin
            if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d, 4'hF, rd);
            rdchk(rows[i].a, rows[i].e);
        end
        $display("test register table done");
        wb(1'b1, OFF_W0_LO, 32'h20000000, 4'hF, rd);
        wb(1'b1, OFF_W1_LO, 32'h5A000000, 4'hF, rd);
        wb(1'b1, OFF_W2, 32'h7C300000, 4'hF, rd);
        hit(32'h3FFFFFFF, 3'b001);
        hit(32'h5AFFFFF0, 3'b010);
        hit(32'h7C3ABCD0, 3'b100);
        hit(32'h1FFFFFFF, 3'b000);
        hit(32'h7C400000, 3'b000);
        $display("test decode done");
        @(posedge mclk);
        eeprom_load <= 1'b1;
        eeprom_hdr  <= 7'h7F;
        @(posedge mclk);
        eeprom_load <= 1'b0;
        rdchk(OFF_MISC, 32'h007FFCFF);
        wb(1'b1, OFF_MISC, 32'hFFFFFF08, 4'h1, rd);
        rdchk(OFF_MISC, 32'h007FFC08);
        cmd(8'h04, CMD_MEM_READ);
        cmd(8'h08, CMD_READ_LINE);
        cmd(8'h09, CMD_READ_MULT);
        cmd(8'hFF, CMD_READ_MULT);
        $display("test read command done");
        wb(1'b1, OFF_MISC, 32'h00000700, 4'h2, rd);
        rdchk(OFF_MISC, 32'h007F0408);
        @(posedge mclk);
        tenure_active <= 1'b1;
        grant         <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({31'h0, tenure_give_up}, 32'h0);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk({31'h0, tenure_give_up}, 32'h0);
        @(posedge mclk);
        @(negedge mclk);
        chk({31'h0, tenure_give_up}, 32'h1);
        @(posedge mclk);
        grant <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({31'h0, tenure_give_up}, 32'h0);
        @(posedge mclk);
        tenure_active <= 1'b0;
        $display("test tenure done");
        @(posedge mclk);
        satellite_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk({31'h0, satellite_mode}, 32'h1);
        wb(1'b1, OFF_W2, 32'h00000000, 4'hF, rd);
        rdchk(OFF_W0_LO, 32'h00000000);
        @(posedge mclk);
        satellite_pin <= 1'b0;
        repeat (6) @(posedge mclk);
        rdchk(OFF_W0_LO, 32'h20000008);
        rdchk(OFF_W2, 32'h7C300000);
        $display("test satellite done");
        do_reset();
        rdchk(OFF_MISC, 32'h00000000);
        rdchk(OFF_W1_LO, 32'h00000008);
        cmd(8'h00, CMD_MEM_READ);
        $display("test second reset done");
        finish_test();
    end
endmodule : pci_target_config_header_bars_test

// [hw/pci_target_config_header_bars.sv]
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
// Summary of operation
// - self-test capable bit reads zero always
// - multi-function flag reads zero always
// - header type read-only, loaded from eeprom
// - after grant loss, quit when timer elapses
// - tenure timer low two bits zero
// - line size picks burst read command
// - no register access in satellite mode
// - window 0 base bits 31:29 only
// - window 1 base bits 31:24 only
// - window 2 base bits 31:20 only
// - windows 0 and 1 read prefetchable
// - window 2 reads not prefetchable
// - memory type field reads 00
// - space kind indicator reads zero
// - no dual-address cycles, upper bases unused
module pci_target_config_header_bars
    import pci_cfg_pkg::*;
#(
    parameter int TIMER_W = 8
) (
    input  wire logic        mclk,            // 250 MHz clock
    input  wire logic        srst,            // sync reset
    input  wire logic        cyc_i,           // wishbone cycle
    input  wire logic        stb_i,           // wishbone strobe
    input  wire logic        we_i,            // write enable
    input  wire logic [15:0] adr_i,           // byte address
    input  wire logic [31:0] dat_i,           // write data
    input  wire logic [3:0]  sel_i,           // byte lanes
    output logic      [31:0] dat_o,           // read data
    output logic             ack_o,           // acknowledge
    input  wire logic        satellite_pin,   // satellite strap, async
    input  wire logic        eeprom_load,     // header type load strobe
    input  wire logic [6:0]  eeprom_hdr,      // loaded header type
    input  wire logic        tenure_active,   // we own the bus
    input  wire logic        grant,           // grant present
    output logic             tenure_give_up,  // quit the access
    input  wire logic        cmd_req,         // pick burst read cmd
    input  wire logic [7:0]  burst_words,     // burst length in words
    output logic      [3:0]  read_cmd,        // chosen read command
    input  wire logic        addr_valid,      // pci address phase
    input  wire logic [31:0] pci_addr,        // pci address
    output logic      [2:0]  window_hit,      // window claimed
    output logic             satellite_mode   // filtered strap
);
    generate
        if (TIMER_W != 8) begin : g_bad_timer
            $error("TIMER_W must be 8");
        end
    endgenerate

    logic [6:0]  header_type;
    logic [5:0]  tenure_hi;
    logic [7:0]  line_size;
    logic [2:0]  base0;
    logic [7:0]  base1;
    logic [11:0] base2;
    logic [31:0] next_rdata;
    logic        sat_s1;
    logic        sat_s2;
    logic        sat_s3;
    logic        access;
    logic        wr;
    logic [31:0] misc_word;
    logic [7:0]  tenure_limit;
    logic [31:0] misc_merged;

    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    function automatic logic match(
        input logic [31:0] addr,
        input logic [31:0] base,
        input int          lsb
    );
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 32; i++) begin
            if (i >= lsb && addr[i] != base[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : match

    // strap filter: change counts once stages 2 and 3 agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            sat_s1 <= 1'b0;
            sat_s2 <= 1'b0;
            sat_s3 <= 1'b0;
        end else begin
            sat_s1 <= satellite_pin;
            sat_s2 <= sat_s1;
            sat_s3 <= sat_s2;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            satellite_mode <= 1'b0;
        end else if (sat_s2 == sat_s3) begin
            satellite_mode <= sat_s3;
        end
    end

    assign access = cyc_i && stb_i && !ack_o;
    assign wr     = access && we_i && !satellite_mode;

    assign tenure_limit = {tenure_hi, 2'b00};
    assign misc_word = {1'b0,
                        7'h00,
                        1'b0,
                        header_type,
                        tenure_limit,
                        line_size};
    assign misc_merged = lane_merge(misc_word, dat_i, sel_i);

    // header register
    always_ff @(posedge mclk) begin
        if (srst) begin
            header_type <= HDR_RST;
        end else if (eeprom_load) begin
            header_type <= eeprom_hdr;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tenure_hi <= TIMER_RST[7:TIMER_FIXED];
        end else if (wr && adr_i == OFF_MISC) begin
            tenure_hi <= misc_merged[15:10];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            line_size <= LINE_RST;
        end else if (wr && adr_i == OFF_MISC) begin
            line_size <= misc_merged[7:0];
        end
    end

    // window bases; upper-base writes are dropped
    always_ff @(posedge mclk) begin
        if (srst) begin
            base0 <= W0_RST;
        end else if (wr && sel_i[3] && adr_i == OFF_W0_LO) begin
            base0 <= dat_i[31:W0_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            base1 <= W1_RST;
        end else if (wr && sel_i[3] && adr_i == OFF_W1_LO) begin
            base1 <= dat_i[31:W1_LSB];
        end
    end

    // two lanes land independently
    always_ff @(posedge mclk) begin
        if (srst) begin
            base2 <= W2_RST;
        end else if (wr && adr_i == OFF_W2) begin
            if (sel_i[3]) begin
                base2[11:4] <= dat_i[31:24];
            end
            if (sel_i[2]) begin
                base2[3:0] <= dat_i[23:W2_LSB];
            end
        end
    end

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (!satellite_mode) begin
            unique case (adr_i)
                OFF_MISC:  next_rdata = misc_word;
                OFF_W0_LO: next_rdata = {base0, 25'h0, BAR_LOW_PREF};
                OFF_W1_LO: next_rdata = {base1, 20'h0, BAR_LOW_PREF};
                OFF_W2:    next_rdata = {base2, 16'h0, BAR_LOW_NP};
                default:   next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // one-cycle ack; unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            if (access && !we_i) begin
                dat_o <= next_rdata;
            end
        end
    end

    // burst read command from line size
    always_ff @(posedge mclk) begin
        if (srst) begin
            read_cmd <= CMD_MEM_READ;
        end else if (cmd_req) begin
            if (line_size == 8'h00 || burst_words < line_size) begin
                read_cmd <= CMD_MEM_READ;
            end else if (burst_words == line_size) begin
                read_cmd <= CMD_READ_LINE;
            end else begin
                read_cmd <= CMD_READ_MULT;
            end
        end
    end

    // target decode, single-address only
    always_ff @(posedge mclk) begin
        if (srst) begin
            window_hit <= 3'h0;
        end else if (addr_valid) begin
            window_hit[0] <= match(pci_addr, {base0, 29'h0}, W0_LSB);
            window_hit[1] <= match(pci_addr, {base1, 24'h0}, W1_LSB);
            window_hit[2] <= match(pci_addr, {base2, 20'h0}, W2_LSB);
        end else begin
            window_hit <= 3'h0;
        end
    end

    tenure_timer #(
        .WIDTH (TIMER_W)
    ) u_tenure (
        .mclk          (mclk),
        .srst          (srst),
        .limit         (tenure_limit),
        .tenure_active (tenure_active),
        .grant         (grant),
        .give_up       (tenure_give_up)
    );

    self_test_zero_a: assert property (@(posedge mclk) disable iff (srst)
        ack_o && !we_i && adr_i == OFF_MISC |-> !dat_o[SELF_TEST_BIT])
        else $error("self-test bit read as one");
    multi_fn_zero_a: assert property (@(posedge mclk) disable iff (srst)
        ack_o && !we_i && adr_i == OFF_MISC |-> !dat_o[MULTI_FN_BIT])
        else $error("multi-function flag read as one");
    header_locked_a: assert property (@(posedge mclk) disable iff (srst)
        !eeprom_load |=> $stable(header_type))
        else $error("header type changed without load");
    tenure_low_a: assert property (@(posedge mclk) disable iff (srst)
        ack_o && !we_i && adr_i == OFF_MISC && !satellite_mode |-> dat_o[9:8] == 2'b00)
        else $error("tenure timer low bits not zero");
    line_cmd_a: assert property (@(posedge mclk) disable iff (srst)
        cmd_req && line_size != 8'h00 && burst_words > line_size |=> read_cmd == CMD_READ_MULT)
        else $error("wrong burst read command");
    satellite_block_a: assert property (@(posedge mclk) disable iff (srst)
        access && satellite_mode |=> ack_o && $stable(base0) && $stable(line_size) && (we_i || dat_o == 32'h0))
        else $error("register reached in satellite mode");
    window0_read_a: assert property (@(posedge mclk) disable iff (srst)
        access && !we_i && adr_i == OFF_W0_LO && !satellite_mode
        |=> dat_o[28:0] == {25'h0, BAR_LOW_PREF} && dat_o[31:29] == base0)
        else $error("window 0 base reads wrong");
    window1_write_a: assert property (@(posedge mclk) disable iff (srst)
        wr && adr_i == OFF_W1_LO && sel_i[3] |=> base1 == $past(dat_i[31:24]))
        else $error("window 1 base not written");
    window2_read_a: assert property (@(posedge mclk) disable iff (srst)
        access && !we_i && adr_i == OFF_W2 && !satellite_mode
        |=> dat_o[19:0] == {16'h0, BAR_LOW_NP})
        else $error("window 2 low bits wrong");
    upper_zero_a: assert property (@(posedge mclk) disable iff (srst)
        access && !we_i && (adr_i == OFF_W0_HI || adr_i == OFF_W1_HI) |=> dat_o == 32'h0)
        else $error("upper base reads nonzero");
    window_claim_a: assert property (@(posedge mclk) disable iff (srst)
        addr_valid && pci_addr[31:20] == base2 && $stable(base2) |=> window_hit[2])
        else $error("window 2 address not claimed");
    window0_write_a: assert property (@(posedge mclk) disable iff (srst)
        wr && adr_i == OFF_W0_LO && sel_i[3] |=> base0 == $past(dat_i[31:W0_LSB]))
        else $error("window 0 base not written");
    window2_write_a: assert property (@(posedge mclk) disable iff (srst)
        wr && adr_i == OFF_W2 && sel_i[3] && sel_i[2] |=> base2 == $past(dat_i[31:W2_LSB]))
        else $error("window 2 base not written");
    window1_read_a: assert property (@(posedge mclk) disable iff (srst)
        access && !we_i && adr_i == OFF_W1_LO && !satellite_mode
        |=> dat_o[23:0] == {20'h0, BAR_LOW_PREF} && dat_o[31:24] == base1)
        else $error("window 1 base reads wrong");
    bar_type_a: assert property (@(posedge mclk) disable iff (srst)
        ack_o && !we_i && (adr_i == OFF_W0_LO || adr_i == OFF_W1_LO || adr_i == OFF_W2)
        |-> dat_o[2:0] == 3'b000)
        else $error("base type or space bits nonzero");
    misc_reserved_a: assert property (@(posedge mclk) disable iff (srst)
        ack_o && !we_i && adr_i == OFF_MISC |-> dat_o[30:24] == 7'h00)
        else $error("reserved header bits nonzero");
    header_load_a: assert property (@(posedge mclk) disable iff (srst)
        eeprom_load |=> header_type == $past(eeprom_hdr))
        else $error("header type not loaded");
    line_read_a: assert property (@(posedge mclk) disable iff (srst)
        access && !we_i && adr_i == OFF_MISC && !satellite_mode
        |=> dat_o[7:0] == line_size)
        else $error("line size reads wrong");
    line_mem_a: assert property (@(posedge mclk) disable iff (srst)
        cmd_req && (line_size == 8'h00 || burst_words < line_size) |=> read_cmd == CMD_MEM_READ)
        else $error("expected plain memory read");
    line_eq_a: assert property (@(posedge mclk) disable iff (srst)
        cmd_req && line_size != 8'h00 && burst_words == line_size |=> read_cmd == CMD_READ_LINE)
        else $error("expected read line command");
    strap_filter_a: assert property (@(posedge mclk) disable iff (srst)
        $changed(satellite_mode) |-> satellite_mode == $past(sat_s3))
        else $error("satellite mode changed unfiltered");
    window_miss_a: assert property (@(posedge mclk) disable iff (srst)
        !addr_valid |=> window_hit == 3'h0)
        else $error("window claimed without address");
    window0_claim_a: assert property (@(posedge mclk) disable iff (srst)
        addr_valid && pci_addr[31:29] == base0 && $stable(base0) |=> window_hit[0])
        else $error("window 0 address not claimed");
    window1_claim_a: assert property (@(posedge mclk) disable iff (srst)
        addr_valid && pci_addr[31:24] == base1 && $stable(base1) |=> window_hit[1])
        else $error("window 1 address not claimed");

    bar_write_c: cover property (@(posedge mclk) disable iff (srst)
        wr && adr_i == OFF_W0_LO ##2 access && !we_i && adr_i == OFF_W0_LO);
    hit_c: cover property (@(posedge mclk) disable iff (srst)
        addr_valid ##1 window_hit[0]);
    satellite_c: cover property (@(posedge mclk) disable iff (srst)
        access && satellite_mode);
    read_line_c: cover property (@(posedge mclk) disable iff (srst)
        cmd_req && burst_words == line_size ##1 read_cmd == CMD_READ_LINE);
endmodule : pci_target_config_header_bars

// [hw/tenure_timer.sv]
`timescale 1ns/10ps
module tenure_timer
    import pci_cfg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,          // clock
    input  wire logic             srst,          // sync reset
    input  wire logic [WIDTH-1:0] limit,         // tenure length in clocks
    input  wire logic             tenure_active, // we own the bus
    input  wire logic             grant,         // grant still present
    output logic                  give_up        // end the access
);
    generate
        if (WIDTH < 3) begin : g_bad_width
            $error("tenure_timer WIDTH must be at least 3");
        end
    endgenerate

    tenure_state_type state;
    logic [WIDTH-1:0] count;
    logic [WIDTH:0]   elapsed;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= TEN_IDLE;
            count <= '0;
        end else begin
            unique case (state)
                TEN_IDLE: begin
                    count <= '0;
                    if (tenure_active) begin
                        state <= (limit == '0) ? TEN_EXPIRED : TEN_COUNT;
                    end
                end
                TEN_COUNT: begin
                    count <= count + 1'b1;
                    if (!tenure_active) begin
                        state <= TEN_IDLE;
                    end else if (count + 1'b1 >= limit) begin
                        state <= TEN_EXPIRED;
                    end
                end
                TEN_EXPIRED: begin
                    if (!tenure_active) begin
                        state <= TEN_IDLE;
                    end
                end
            endcase
        end
    end

    // timer ran out and grant is gone
    always_ff @(posedge mclk) begin
        if (srst) begin
            give_up <= 1'b0;
        end else begin
            give_up <= (state == TEN_EXPIRED) && tenure_active && !grant;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || !tenure_active) begin
            elapsed <= '0;
        end else if (!elapsed[WIDTH]) begin
            elapsed <= elapsed + 1'b1;
        end
    end

    tenure_abort_a: assert property (@(posedge mclk) disable iff (srst)
        state == TEN_EXPIRED && tenure_active && !grant |=> give_up)
        else $error("no give-up after timer expiry");
    tenure_early_a: assert property (@(posedge mclk) disable iff (srst)
        give_up |-> elapsed >= {1'b0, limit})
        else $error("give-up before timer elapsed");
    tenure_cov_c: cover property (@(posedge mclk) disable iff (srst)
        tenure_active && !grant ##1 give_up);
endmodule : tenure_timer
